// file: logic/sso_core.sv
// stack transfer, return and single-bit shift execution with AHB-Lite register view
`timescale 1ns/1ps
`default_nettype none
`include "sso_defines.svh"
module sso_core (
  input  wire logic             mclk,
  input  wire logic             arst_n,
  input  wire sso_pkg::sso_cmd_t cmd,
  input  wire logic             cmd_valid,
  output logic                  cmd_ready,
  output logic                  done,
  output logic [15:0]           result,
  output logic                  result_we,
  output sso_pkg::sso_mem_t     mem,
  input  wire logic [15:0]      mem_rdata,
  output logic                  wdt_violation,
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic [31:0]           hrdata,
  output logic                  hreadyout,
  output logic                  hresp
);
  // register byte addresses
  localparam logic [3:0] RA_SP = 4'h0;
  localparam logic [3:0] RA_SR = 4'h4;
  localparam logic [3:0] RA_PC = 4'h8;
  localparam logic [3:0] RA_ST = 4'hC;

  sso_pkg::sso_state_t state;
  sso_pkg::sso_state_t next_state;
  sso_pkg::sso_cmd_t   cur;
  logic [15:0] stack_ptr;
  logic [15:0] flag_register;
  logic [15:0] program_counter;
  logic [3:0]  wait_cnt;
  logic        viol_seen;

  // shift datapath, word and byte forms
  wire [15:0] opw   = cur.operand;
  wire [7:0]  opb   = cur.operand[7:0];
  wire        c_in  = flag_register[`SSO_FLAG_C];
  wire        is_rol = (cur.op == sso_pkg::SSO_OP_ROL);
  wire        fill  = is_rol ? c_in : 1'b0;
  wire [15:0] shl_w = {opw[14:0], fill};
  wire [7:0]  shl_b = {opb[6:0], fill};
  wire [15:0] shr_w = {opw[15], opw[15:1]};
  wire [7:0]  shr_b = {opb[7], opb[7:1]};
  wire        ovf_w = (opw >= `SSO_OVF_W_LO) && (opw < `SSO_OVF_W_HI);
  wire        ovf_b = (opb >= `SSO_OVF_B_LO) && (opb < `SSO_OVF_B_HI);
  wire        is_shr = (cur.op == sso_pkg::SSO_OP_SHR);
  wire [15:0] sh_res = is_shr ? (cur.byte_op ? {8'h00, shr_b} : shr_w)
                              : (cur.byte_op ? {8'h00, shl_b} : shl_w);
  wire        sh_c   = is_shr ? opw[0]
                              : (cur.byte_op ? opb[7] : opw[15]);
  wire        sh_v   = is_shr ? 1'b0 : (cur.byte_op ? ovf_b : ovf_w);
  wire        sh_n   = cur.byte_op ? sh_res[7] : sh_res[15];
  wire        sh_z   = cur.byte_op ? (sh_res[7:0] == 8'h00) : (sh_res == 16'h0000);
  wire [15:0] sh_flags = {flag_register[15:9], sh_v, flag_register[7:3],
                          sh_n, sh_z, sh_c};

  wire is_shift = (cur.op == sso_pkg::SSO_OP_SHL) || is_rol || is_shr;
  // busy cycles after accept, decoded from the offered command; others take one
  wire [3:0] idle_len =
    (cmd.op == sso_pkg::SSO_OP_IDLE_MOV_IDX) ? `SSO_CYC_MOV_IDX :
    (cmd.op == sso_pkg::SSO_OP_IDLE_MOV_IND) ? `SSO_CYC_MOV_IND :
    (cmd.op == sso_pkg::SSO_OP_IDLE_BIC_IDX) ? `SSO_CYC_BIC_IDX :
    (cmd.op == sso_pkg::SSO_OP_IDLE_JMP)     ? `SSO_CYC_JMP_REL : `SSO_CYC_ONE;

  // popped value shaping
  wire [15:0] pop_val = (cur.byte_op && cur.dst_is_reg) ? {8'h00, mem_rdata[7:0]}
                                                        : mem_rdata;
  wire [15:0] sp_up   = stack_ptr + `SSO_SP_STEP;
  wire [15:0] sp_dn   = stack_ptr - `SSO_SP_STEP;
  wire [15:0] sp_even = {stack_ptr[15:1], 1'b0};

  // bus slave: single-cycle, zero wait
  logic        ap_valid;
  logic        ap_write;
  logic [3:0]  ap_addr;
  logic        ap_map;
  wire         ahb_go   = hsel && hready && htrans[1];
  wire         wr_now   = ap_valid && ap_write && ap_map;
  wire [15:0]  bus_wd   = hwdata[15:0];
  wire         bus_busy = (state != sso_pkg::SSO_ST_IDLE);

  assign cmd_ready = (state == sso_pkg::SSO_ST_IDLE) && !wr_now;
  wire   accept    = cmd_valid && cmd_ready;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_comb begin
    next_state = state;
    unique case (state)
      sso_pkg::SSO_ST_IDLE: begin
        if (accept) begin
          unique case (cmd.op)
            sso_pkg::SSO_OP_POP,
            sso_pkg::SSO_OP_SUB_EXIT,
            sso_pkg::SSO_OP_IRQ_EXIT: next_state = sso_pkg::SSO_ST_RD1;
            sso_pkg::SSO_OP_PUSH:     next_state = sso_pkg::SSO_ST_WR;
            default:                  next_state = sso_pkg::SSO_ST_WAIT;
          endcase
        end
      end
      sso_pkg::SSO_ST_RD1: next_state = (cur.op == sso_pkg::SSO_OP_IRQ_EXIT) ?
                                        sso_pkg::SSO_ST_RD2 : sso_pkg::SSO_ST_IDLE;
      sso_pkg::SSO_ST_RD2: next_state = sso_pkg::SSO_ST_IDLE;
      sso_pkg::SSO_ST_WR:  next_state = sso_pkg::SSO_ST_IDLE;
      sso_pkg::SSO_ST_WAIT: next_state = (wait_cnt <= 4'h1) ? sso_pkg::SSO_ST_IDLE
                                                            : sso_pkg::SSO_ST_WAIT;
      default: next_state = sso_pkg::SSO_ST_IDLE;
    endcase
  end

  // memory request, combinational on state
  always_comb begin
    mem.req   = 1'b0;
    mem.we    = 1'b0;
    mem.addr  = sp_even;
    mem.wdata = cur.operand;
    unique case (state)
      sso_pkg::SSO_ST_RD1, sso_pkg::SSO_ST_RD2: mem.req = 1'b1;
      sso_pkg::SSO_ST_WR: begin
        mem.req   = 1'b1;
        mem.we    = 1'b1;
        mem.wdata = cur.byte_op ? {8'h00, cur.operand[7:0]} : cur.operand;
      end
      default: mem.req = 1'b0;
    endcase
  end
  // memory is assumed to answer reads combinationally in the request cycle

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state <= sso_pkg::SSO_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cur      <= '0;
      wait_cnt <= 4'h0;
    end else if (accept) begin
      cur      <= cmd;
      wait_cnt <= idle_len;
    end else if (state == sso_pkg::SSO_ST_WAIT) begin
      wait_cnt <= wait_cnt - 4'h1;
    end else if (state == sso_pkg::SSO_ST_IDLE) begin
      wait_cnt <= 4'h0;
    end
  end

  // marks the first wait cycle, when the captured command is in place
  logic wait_loaded;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wait_loaded <= 1'b0;
    end else begin
      wait_loaded <= accept;
    end
  end

  // architectural state: stack pointer, flags, program counter
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      stack_ptr       <= `SSO_SP_RESET;
      flag_register   <= 16'h0000;
      program_counter <= 16'h0000;
    end else begin
      unique case (state)
        sso_pkg::SSO_ST_RD1: begin
          stack_ptr <= sp_up;
          if (cur.op == sso_pkg::SSO_OP_IRQ_EXIT) begin
            flag_register <= mem_rdata;
          end else if (cur.op == sso_pkg::SSO_OP_SUB_EXIT) begin
            program_counter <= mem_rdata;
          end else if (cur.dst_is_flags) begin
            flag_register <= pop_val;
          end
        end
        sso_pkg::SSO_ST_RD2: begin
          stack_ptr       <= sp_up;
          program_counter <= mem_rdata;
        end
        sso_pkg::SSO_ST_IDLE: begin
          if (accept && cmd.op == sso_pkg::SSO_OP_PUSH) begin
            stack_ptr <= sp_dn;
          end else if (wr_now && ap_addr == RA_SP) begin
            stack_ptr <= bus_wd;
          end else if (wr_now && ap_addr == RA_SR) begin
            flag_register <= bus_wd;
          end else if (wr_now && ap_addr == RA_PC) begin
            program_counter <= bus_wd;
          end
        end
        sso_pkg::SSO_ST_WAIT: begin
          if (wait_loaded && is_shift) begin
            flag_register <= sh_flags;
          end
        end
        default: stack_ptr <= stack_ptr;
      endcase
    end
  end

  // result strobe and sticky watchdog violation
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      done          <= 1'b0;
      result        <= 16'h0000;
      result_we     <= 1'b0;
      wdt_violation <= 1'b0;
      viol_seen     <= 1'b0;
    end else begin
      done      <= (state != sso_pkg::SSO_ST_IDLE) &&
                   (next_state == sso_pkg::SSO_ST_IDLE);
      result_we <= 1'b0;
      if (state == sso_pkg::SSO_ST_RD1 && cur.op == sso_pkg::SSO_OP_POP &&
          !cur.dst_is_flags) begin
        result    <= pop_val;
        result_we <= 1'b1;
      end else if (state == sso_pkg::SSO_ST_WAIT && wait_loaded && is_shift) begin
        result    <= sh_res;
        result_we <= 1'b1;
      end
      wdt_violation <= 1'b0;
      if (state == sso_pkg::SSO_ST_WAIT && wait_loaded &&
          cur.op == sso_pkg::SSO_OP_WDT_WR &&
          cur.operand[15:8] != `SSO_WDT_KEY) begin
        wdt_violation <= 1'b1;
        viol_seen     <= 1'b1;
      end else if (wr_now && ap_addr == RA_ST && bus_wd[0]) begin
        viol_seen     <= 1'b0;
      end
    end
  end

  // AHB-Lite address phase capture
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_addr  <= 4'h0;
      ap_map   <= 1'b0;
    end else if (hready) begin
      ap_valid <= ahb_go;
      ap_write <= hwrite;
      ap_addr  <= haddr[3:0];
      // upper address bits must be zero, else the low nibble would alias
      ap_map   <= (haddr[31:4] == 28'h0000000);
    end
  end

  wire [15:0] rd_mux = !ap_map             ? 16'h0000 :
                       (ap_addr == RA_SP) ? stack_ptr :
                       (ap_addr == RA_SR) ? flag_register :
                       (ap_addr == RA_PC) ? program_counter :
                       (ap_addr == RA_ST) ? {14'h0000, bus_busy, viol_seen} : 16'h0000;
  assign hrdata = {16'h0000, rd_mux};
endmodule
`default_nettype wire

// file: logic/sso_defines.svh
// constants for the stack and shift execution block
`ifndef SSO_DEFINES_SVH
`define SSO_DEFINES_SVH
`define SSO_FLAG_C          0
`define SSO_FLAG_Z          1
`define SSO_FLAG_N          2
`define SSO_FLAG_GIE        3
`define SSO_FLAG_CORE_HALT  4
`define SSO_FLAG_OSC_OFF    5
`define SSO_FLAG_V          8
`define SSO_SP_STEP         16'h0002
`define SSO_OVF_W_LO        16'h4000
`define SSO_OVF_W_HI        16'hC000
`define SSO_OVF_B_LO        8'h40
`define SSO_OVF_B_HI        8'hC0
`define SSO_WDT_ADDR        16'h0120
`define SSO_WDT_KEY         8'h5A
`define SSO_CYC_MOV_IDX     4'h6
`define SSO_CYC_MOV_IND     4'h5
`define SSO_CYC_BIC_IDX     4'h4
`define SSO_CYC_JMP_REL     4'h2
`define SSO_CYC_ONE         4'h1
`define SSO_SP_RESET        16'h0000
`endif

// file: logic/sso_pkg.sv
// types for the stack and shift execution block
`default_nettype none
package sso_pkg;
  typedef enum logic [3:0] {
    SSO_OP_POP     = 4'h0,
    SSO_OP_PUSH    = 4'h1,
    SSO_OP_SUB_EXIT = 4'h2,
    SSO_OP_IRQ_EXIT = 4'h3,
    SSO_OP_SHL     = 4'h4,
    SSO_OP_ROL     = 4'h5,
    SSO_OP_SHR     = 4'h6,
    SSO_OP_IDLE_MOV_IDX = 4'h7,
    SSO_OP_IDLE_MOV_IND = 4'h8,
    SSO_OP_IDLE_BIC_IDX = 4'h9,
    SSO_OP_IDLE_JMP = 4'hA,
    SSO_OP_IDLE_ONE = 4'hB,
    SSO_OP_WDT_WR  = 4'hC
  } sso_op_t;

  typedef struct packed {
    sso_op_t     op;
    logic        byte_op;
    logic        dst_is_reg;
    logic        dst_is_flags;
    logic [15:0] operand;
  } sso_cmd_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } sso_mem_t;

  typedef enum logic [4:0] {
    SSO_ST_IDLE  = 5'b00001,
    SSO_ST_RD1   = 5'b00010,
    SSO_ST_RD2   = 5'b00100,
    SSO_ST_WR    = 5'b01000,
    SSO_ST_WAIT  = 5'b10000
  } sso_state_t;
endpackage
`default_nettype wire

// file: testbench/sso_checker.sv
// assertions on the stack and shift block ports
`timescale 1ns/1ps
`default_nettype none
module sso_checker (
  input wire logic              mclk,
  input wire logic              arst_n,
  input wire sso_pkg::sso_cmd_t cmd,
  input wire logic              cmd_valid,
  input wire logic              cmd_ready,
  input wire logic              done,
  input wire logic [15:0]       result,
  input wire logic              result_we,
  input wire sso_pkg::sso_mem_t mem
);
  sso_pkg::sso_cmd_t cq;
  wire logic         acc = cmd_valid && cmd_ready;
  // operand kept so a late result can be tied to its cause
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) cq <= '0;
    else if (acc) cq <= cmd;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  a_even_word: assert property (mem.req |-> !mem.addr[0])
    else $error("odd stack address");
  a_pop_read: assert property (acc && cmd.op == sso_pkg::SSO_OP_POP
    |=> mem.req && !mem.we ##1 done) else $error("pop read or done late");
  a_push_data: assert property (acc && cmd.op == sso_pkg::SSO_OP_PUSH |=> mem.req && mem.we
    && mem.wdata == (cq.byte_op ? {8'h00, cq.operand[7:0]} : cq.operand) ##1 done)
    else $error("push write wrong");
  a_sub_exit: assert property (acc && cmd.op == sso_pkg::SSO_OP_SUB_EXIT
    |=> mem.req && !mem.we ##1 done) else $error("subroutine exit timing");
  a_irq_two_reads: assert property (acc && cmd.op == sso_pkg::SSO_OP_IRQ_EXIT
    |=> (mem.req && !mem.we) ##1 (mem.req && !mem.we && mem.addr == $past(mem.addr) + 16'h0002)
    ##1 done) else $error("interrupt exit reads wrong");
  a_shl_word: assert property (acc && cmd.op == sso_pkg::SSO_OP_SHL && !cmd.byte_op
    |-> ##2 done && result == {cq.operand[14:0], 1'h0}) else $error("left shift result");
  a_shr_word: assert property (acc && cmd.op == sso_pkg::SSO_OP_SHR && !cmd.byte_op
    |-> ##2 done && result == {cq.operand[15], cq.operand[15:1]}) else $error("right shift");
  a_shr_byte: assert property (acc && cmd.op == sso_pkg::SSO_OP_SHR && cmd.byte_op
    |-> ##2 result == {8'h00, cq.operand[7], cq.operand[7:1]}) else $error("byte right shift");
  a_byte_pop: assert property (acc && cmd.op == sso_pkg::SSO_OP_POP && cmd.byte_op
    && cmd.dst_is_reg |-> ##2 result_we && result[15:8] == 8'h00) else $error("byte pop high");
  c_push: cover property (acc && cmd.op == sso_pkg::SSO_OP_PUSH);
  c_irq: cover property (acc && cmd.op == sso_pkg::SSO_OP_IRQ_EXIT);
  c_rol: cover property (acc && cmd.op == sso_pkg::SSO_OP_ROL);
endmodule
bind sso_core sso_checker i_chk (
  .mclk(mclk), .arst_n(arst_n), .cmd(cmd), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
  .done(done), .result(result), .result_we(result_we), .mem(mem)
);
`default_nettype wire

// file: testbench/sso_stack_mem.sv
// data memory model holding the system stack
`timescale 1ns/1ps
`default_nettype none
module sso_stack_mem (
  input wire logic              mclk,
  input wire sso_pkg::sso_mem_t mem,
  output logic [15:0]           mem_rdata
);
  logic [15:0] ram [0:255];
  always_ff @(posedge mclk) begin
    if (mem.req && mem.we) ram[mem.addr[8:1]] <= mem.wdata;
  end
  // outside a read the data is inverted so a stale sample shows up
  assign mem_rdata = (mem.req && !mem.we) ? ram[mem.addr[8:1]] : ~ram[mem.addr[8:1]];
endmodule
`default_nettype wire

// file: testbench/stack_and_shift_ops_tb_top.sv
// self-checking bench for the stack and shift block
`timescale 1ns/1ps
`default_nettype none
`include "sso_defines.svh"
module stack_and_shift_ops_tb_top;
  logic              mclk = 1'h0;
  logic              arst_n = 1'h0;
  sso_pkg::sso_cmd_t cmd = '0;
  logic              cmd_valid = 1'h0;
  logic              hsel = 1'h0;
  logic [31:0]       haddr = '0;
  logic [1:0]        htrans = '0;
  logic              hwrite = 1'h0;
  logic [2:0]        hsize = '0;
  logic [31:0]       hwdata = '0;
  wire logic         cmd_ready, done, result_we, hreadyout, hresp, wdt_violation;
  wire logic [15:0]  result, mem_rdata;
  wire logic [31:0]  hrdata;
  wire sso_pkg::sso_mem_t mem;
  int                err_total = 0;
  int                checks = 0;
  logic [31:0]       rd;
  logic [15:0]       res;
  int                cyc = 0;
  logic              vio = 1'h0;
  logic              to_flags = 1'h0;
  always #2.5 mclk = ~mclk;
  sso_core i_dut (.mclk(mclk), .arst_n(arst_n), .cmd(cmd), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .done(done), .result(result), .result_we(result_we), .mem(mem),
    .mem_rdata(mem_rdata), .wdt_violation(wdt_violation), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
  sso_stack_mem i_mem (.mclk(mclk), .mem(mem), .mem_rdata(mem_rdata));
  task automatic close_out();
    if (err_total == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic tick(inout int n);
    n++;
    if (n > 64) begin
      err_total++;
      close_out();
    end
    @(posedge mclk);
  endtask
  task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [15:0] wd);
    int n;
    n = 0;
    @(posedge mclk);
    hsel   <= 1'h1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    hsize  <= 3'h2;
    @(posedge mclk);
    while (hreadyout !== 1'h1) tick(n);
    hsel   <= 1'h0;
    htrans <= 2'h0;
    hwdata <= {16'h0000, wd};
    @(posedge mclk);
    while (hreadyout !== 1'h1) tick(n);
    rd = hrdata;
    cmp("hrdata high half", 16'h0000, rd[31:16]);
    cmp("hresp", 16'h0000, {15'h0000, hresp});
  endtask
  task automatic run(input sso_pkg::sso_op_t op, input logic bt, input logic [15:0] v);
    int n;
    n = 0;
    @(posedge mclk);
    cmd       <= '{op, bt, !to_flags, to_flags, v};
    cmd_valid <= 1'h1;
    @(posedge mclk);
    while (cmd_ready !== 1'h1) tick(n);
    cmd_valid <= 1'h0;
    n = 0;
    @(posedge mclk);
    while (done !== 1'h1) tick(n);
    res = result;
    vio = wdt_violation;
    cyc = n;
  endtask
  task automatic sc_stack();
    ahb(1'h1, 32'h0, 16'h0210);
    ahb(1'h1, 32'h4, 16'h0107);
    run(sso_pkg::SSO_OP_PUSH, 1'h0, 16'h1234);
    ahb(1'h0, 32'h0, 16'h0);
    cmp("sp after push", 16'h020E, rd[15:0]);
    run(sso_pkg::SSO_OP_PUSH, 1'h0, 16'hABCD);
    run(sso_pkg::SSO_OP_POP, 1'h1, 16'h0);
    cmp("byte pop", 16'h00CD, res);
    ahb(1'h0, 32'h0, 16'h0);
    cmp("sp after byte pop", 16'h020E, rd[15:0]);
    run(sso_pkg::SSO_OP_PUSH, 1'h1, 16'hABCD);
    ahb(1'h0, 32'h0, 16'h0);
    cmp("sp after byte push", 16'h020C, rd[15:0]);
    run(sso_pkg::SSO_OP_POP, 1'h0, 16'h0);
    cmp("byte push word", 16'h00CD, res);
    run(sso_pkg::SSO_OP_POP, 1'h0, 16'h0);
    cmp("word pop", 16'h1234, res);
    ahb(1'h0, 32'h4, 16'h0);
    cmp("flags kept", 16'h0107, rd[15:0]);
    ahb(1'h0, 32'h10, 16'h0);
    cmp("unmapped read", 16'h0000, rd[15:0]);
  endtask
  task automatic sc_returns();
    ahb(1'h1, 32'h0, 16'h0300);
    run(sso_pkg::SSO_OP_PUSH, 1'h0, 16'h5678);
    run(sso_pkg::SSO_OP_SUB_EXIT, 1'h0, 16'h0);
    ahb(1'h0, 32'h8, 16'h0);
    cmp("pc after sub exit", 16'h5678, rd[15:0]);
    ahb(1'h0, 32'h0, 16'h0);
    cmp("sp after sub exit", 16'h0300, rd[15:0]);
    run(sso_pkg::SSO_OP_PUSH, 1'h0, 16'h4444);
    run(sso_pkg::SSO_OP_PUSH, 1'h0, 16'h013F);
    ahb(1'h1, 32'h4, 16'h0);
    run(sso_pkg::SSO_OP_IRQ_EXIT, 1'h0, 16'h0);
    ahb(1'h0, 32'h4, 16'h0);
    cmp("flags after irq exit", 16'h013F, rd[15:0]);
    ahb(1'h0, 32'h8, 16'h0);
    cmp("pc after irq exit", 16'h4444, rd[15:0]);
    ahb(1'h0, 32'h0, 16'h0);
    cmp("sp after irq exit", 16'h0300, rd[15:0]);
    run(sso_pkg::SSO_OP_PUSH, 1'h0, 16'h0105);
    to_flags = 1'h1;
    run(sso_pkg::SSO_OP_POP, 1'h0, 16'h0);
    to_flags = 1'h0;
    ahb(1'h0, 32'h4, 16'h0);
    cmp("flags popped", 16'h0105, rd[15:0]);
  endtask
  task automatic sc_idle();
    run(sso_pkg::SSO_OP_IDLE_MOV_IDX, 1'h0, 16'h0);
    cmp("indexed move cycles", {12'h000, `SSO_CYC_MOV_IDX}, cyc[15:0]);
    run(sso_pkg::SSO_OP_IDLE_MOV_IND, 1'h0, 16'h0);
    cmp("indirect move cycles", {12'h000, `SSO_CYC_MOV_IND}, cyc[15:0]);
    run(sso_pkg::SSO_OP_IDLE_BIC_IDX, 1'h0, 16'h0);
    cmp("bit clear cycles", {12'h000, `SSO_CYC_BIC_IDX}, cyc[15:0]);
    run(sso_pkg::SSO_OP_IDLE_JMP, 1'h0, 16'h0);
    cmp("jump cycles", {12'h000, `SSO_CYC_JMP_REL}, cyc[15:0]);
    run(sso_pkg::SSO_OP_IDLE_ONE, 1'h0, 16'h0);
    cmp("single cycles", {12'h000, `SSO_CYC_ONE}, cyc[15:0]);
    run(sso_pkg::SSO_OP_WDT_WR, 1'h0, 16'h0120);
    cmp("unkeyed violation", 16'h0001, {15'h0000, vio});
    ahb(1'h0, 32'hC, 16'h0);
    cmp("sticky violation", 16'h0001, rd[15:0]);
    ahb(1'h1, 32'hC, 16'h0001);
    ahb(1'h0, 32'hC, 16'h0);
    cmp("violation cleared", 16'h0000, rd[15:0]);
    run(sso_pkg::SSO_OP_WDT_WR, 1'h0, {`SSO_WDT_KEY, 8'h00});
    cmp("keyed write", 16'h0000, {15'h0000, vio});
  endtask
  task automatic shift_case(input sso_pkg::sso_op_t op, input logic bt,
                            input logic [15:0] v, input logic ci);
    logic [15:0] e;
    logic        c;
    logic        ov;
    logic        sh;
    logic        cin;
    sh  = (op == sso_pkg::SSO_OP_SHR);
    cin = ci & (op == sso_pkg::SSO_OP_ROL);
    if (bt) begin
      e  = sh ? {8'h00, v[7], v[7:1]} : {8'h00, v[6:0], cin};
      c  = sh ? v[0] : v[7];
      ov = !sh && v[7:0] >= 8'h40 && v[7:0] < 8'hC0;
    end else begin
      e  = sh ? {v[15], v[15:1]} : {v[14:0], cin};
      c  = sh ? v[0] : v[15];
      ov = !sh && v >= 16'h4000 && v < 16'hC000;
    end
    // mode bits set beforehand so a clobber is visible
    ahb(1'h1, 32'h4, {15'h001C, ci});
    run(op, bt, v);
    cmp("shift result", e, res);
    ahb(1'h0, 32'h4, 16'h0);
    cmp("shift flags", {7'h00, ov, 2'h0, 3'h7, bt ? e[7] : e[15],
      bt ? e[7:0] == 8'h00 : e == 16'h0000, c}, rd[15:0]);
  endtask
  task automatic sc_shifts();
    shift_case(sso_pkg::SSO_OP_SHL, 1'h0, 16'h4000, 1'h0);
    shift_case(sso_pkg::SSO_OP_SHL, 1'h0, 16'h3FFF, 1'h1);
    shift_case(sso_pkg::SSO_OP_SHL, 1'h0, 16'hC000, 1'h0);
    shift_case(sso_pkg::SSO_OP_SHL, 1'h0, 16'h8000, 1'h0);
    shift_case(sso_pkg::SSO_OP_ROL, 1'h0, 16'hBFFF, 1'h1);
    shift_case(sso_pkg::SSO_OP_ROL, 1'h1, 16'h0040, 1'h1);
    shift_case(sso_pkg::SSO_OP_SHL, 1'h1, 16'h00C0, 1'h0);
    shift_case(sso_pkg::SSO_OP_SHR, 1'h0, 16'h8001, 1'h0);
    shift_case(sso_pkg::SSO_OP_SHR, 1'h1, 16'h1202, 1'h1);
  endtask
  initial begin
    repeat (8) @(posedge mclk);
    arst_n <= 1'h1;
    sc_stack();
    sc_returns();
    sc_shifts();
    sc_idle();
    close_out();
  end
endmodule
`default_nettype wire
